// [src/uhre_top.sv]
// host receive-endpoint low control and status byte with ahb-lite slave
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// How it works
// [RULE1] every field of the byte resets to zero; register index is 0x116
// [RULE2] writing one to bit 7 forces the data toggle back to zero
// [RULE3] received stall sets bit 6 and raises an interrupt; software clears it
// [RULE4] writing one to bit 5 issues an in transaction for this endpoint
// [RULE5] request bit clears itself when the packet-ready flag is set
// [RULE6] writing one to bit 4 discards the next packet in the fifo
// [RULE7] a flush resets the fifo pointer and clears packet ready
// [RULE8] software flushes only while packet ready is set
// [RULE9] double-buffered fifo may need two flushes to empty
// [RULE10] iso: bit 3 marks crc or stuff error with ready, clears with it
// [RULE11] bulk: bit 3 sets when nak responses outlast the nak limit
// [RULE12] after nak timeout endpoint stays halted until bit 3 cleared
// [RULE13] three attempts without data set bit 2 and raise an interrupt
// [RULE14] bit 2 only for bulk and interrupt; reads zero in iso mode
// [RULE15] read-only bit 1 shows the fifo cannot take more packets
// [RULE16] received data packet sets bit 0 and raises an interrupt
// [RULE17] software clears packet ready after unloading the fifo
// [RULE18] flags software clears are cleared by writing zero, one keeps them
// [RULE19] toggle reset and flush act once per write and read as zero
module uhre_top
(
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // ahb-lite slave
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    // from the usb protocol engine, same clock
    input  wire logic        iso_mode_i,
    input  wire logic        stall_rcvd_i,
    input  wire logic        data_pkt_i,
    input  wire logic        crc_err_i,
    input  wire logic        nak_limit_i,
    input  wire logic        no_data_i,
    input  wire logic        toggle_advance_i,
    input  wire logic        fifo_full_i,
    // to the usb protocol engine
    output logic             in_req_o,
    output logic             halted_o,
    output logic             data_toggle_o,
    output logic             flush_o,
    output logic             irq_event_o
);

    // write zero clears, a hardware set in the same cycle wins
    function automatic logic w0c_next
    (
        input logic cur,
        input logic set,
        input logic wr,
        input logic wbit
    );
        return set | (cur & ~(wr & ~wbit));
    endfunction

    // ---- bus side state
    logic        wr_pend;
    logic        hit_q;

    // ---- register state
    logic        stalled;
    logic        request_packet;
    logic        nak_timeout_flag;
    logic        error_flag;
    logic        packet_ready_flag;
    logic        data_toggle;
    logic [1:0]  retry_cnt;

    // ---- address phase decode
    wire logic       addr_phase;
    wire logic       addr_hit;
    wire logic       rd_start;
    wire logic       wr_start;

    assign addr_phase = hsel_i & hready_i & htrans_i[uhre_pkg::HTRANS_ACTIVE_BIT];
    assign addr_hit   = haddr_i[31:uhre_pkg::ADDR_LSB]
                        == uhre_pkg::REG_BYTE_ADDR[31:uhre_pkg::ADDR_LSB];
    assign rd_start   = addr_phase & ~hwrite_i & addr_hit;
    assign wr_start   = addr_phase & hwrite_i;

    // ---- data phase write strobes
    wire logic       wr_en;
    wire logic [7:0] wd;

    assign wr_en = wr_pend & hit_q;
    assign wd    = hwdata_i[uhre_pkg::REG_WIDTH-1:0];

    wire logic       toggle_reset;
    wire logic       flush_hit;
    wire logic       req_write;

    assign toggle_reset = wr_en & wd[uhre_pkg::BIT_TOGGLE_RESET]; // RULE2 RULE19
    assign flush_hit    = wr_en & wd[uhre_pkg::BIT_FLUSH];        // RULE6 RULE19
    assign req_write    = wr_en;

    // ---- events
    wire logic       set_iso_err;
    wire logic       clr_iso_good;
    wire logic       set_nak;
    wire logic       last_attempt;
    wire logic       set_error;

    assign set_iso_err  = iso_mode_i & data_pkt_i & crc_err_i;    // RULE10
    assign clr_iso_good = iso_mode_i & data_pkt_i & ~crc_err_i;
    assign set_nak      = ~iso_mode_i & nak_limit_i;              // RULE11
    assign last_attempt = retry_cnt == uhre_pkg::RETRY_LIMIT - uhre_pkg::RETRY_STEP;
    assign set_error    = ~iso_mode_i & no_data_i & last_attempt; // RULE13

    // ---- next values
    logic       next_stalled;
    logic       next_ready;
    logic       ready_clr;
    logic       next_nak;
    logic       next_error;
    logic       next_request;
    logic       next_toggle;
    logic [1:0] next_retry;
    logic       next_halted;
    logic [7:0] next_view;

    // stalled flag
    assign next_stalled = w0c_next(stalled, stall_rcvd_i, wr_en,
                                   wd[uhre_pkg::BIT_STALLED]); // RULE3 RULE18

    // packet ready: a new packet wins over software or flush clears
    assign next_ready = data_pkt_i
                        | (packet_ready_flag
                           & ~(wr_en & ~wd[uhre_pkg::BIT_READY])
                           & ~flush_hit); // RULE16 RULE7 RULE18
    assign ready_clr  = packet_ready_flag & ~next_ready;

    // bit 3 carries the iso data error or the bulk nak timeout
    assign next_nak = set_iso_err | set_nak
                      | (nak_timeout_flag
                         & ~(wr_en & ~wd[uhre_pkg::BIT_ERR_NAK])
                         & ~(iso_mode_i & ready_clr)
                         & ~clr_iso_good); // RULE10 RULE11 RULE12 RULE18

    // error flag after the third empty attempt
    assign next_error = w0c_next(error_flag, set_error, wr_en,
                                 wd[uhre_pkg::BIT_ERROR]); // RULE13 RULE18

    // empty attempts counted only in bulk and interrupt mode
    always_comb
    begin
        next_retry = retry_cnt;
        if (data_pkt_i | iso_mode_i | set_error)
        begin
            next_retry = uhre_pkg::RETRY_ZERO;
        end
        else if (no_data_i)
        begin
            next_retry = retry_cnt + uhre_pkg::RETRY_STEP;
        end
    end

    // request packet: dropped when ready sets or the retries run out
    always_comb
    begin
        next_request = request_packet;
        if (data_pkt_i)
        begin
            next_request = 1'h0; // RULE5
        end
        else if (set_error)
        begin
            next_request = 1'h0;
        end
        else if (req_write)
        begin
            next_request = wd[uhre_pkg::BIT_REQUEST]; // RULE4
        end
    end

    // data toggle: a reset request beats an advance in the same cycle
    always_comb
    begin
        next_toggle = data_toggle;
        if (toggle_reset)
        begin
            next_toggle = 1'h0; // RULE2
        end
        else if (toggle_advance_i)
        begin
            next_toggle = ~data_toggle;
        end
    end

    // halt holds the endpoint until software clears bit 3
    assign next_halted = next_nak & ~iso_mode_i; // RULE12

    // ---- engine output causes
    wire logic       next_in_req;
    wire logic       next_irq;

    assign next_in_req = next_request & ~next_halted;           // RULE4 RULE12
    assign next_irq    = stall_rcvd_i | data_pkt_i | set_error; // RULE3 RULE13 RULE16

    // read view after this cycle's updates, so a read right after a write sees it
    always_comb
    begin
        next_view = uhre_pkg::REG_RESET;
        next_view[uhre_pkg::BIT_STALLED] = next_stalled;
        next_view[uhre_pkg::BIT_REQUEST] = next_request;
        next_view[uhre_pkg::BIT_ERR_NAK] = next_nak;
        next_view[uhre_pkg::BIT_ERROR]   = next_error & ~iso_mode_i; // RULE14
        next_view[uhre_pkg::BIT_FULL]    = fifo_full_i;             // RULE15
        next_view[uhre_pkg::BIT_READY]   = next_ready;
    end

    // ---- bus slave flops
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            wr_pend     <= 1'h0;
            hit_q       <= 1'h0;
            hreadyout_o <= uhre_pkg::HREADY_HIGH;
            hresp_o     <= uhre_pkg::HRESP_OKAY;
        end
        else
        begin
            if (hready_i)
            begin
                wr_pend <= wr_start;
                hit_q   <= addr_hit;
            end
            // zero wait states, always okay
            hreadyout_o <= uhre_pkg::HREADY_HIGH;
            hresp_o     <= uhre_pkg::HRESP_OKAY;
        end
    end

    // read data captured at the address edge; unmapped reads give zero
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            hrdata_o <= uhre_pkg::HRDATA_ZERO;
        end
        else if (rd_start)
        begin
            hrdata_o <= {uhre_pkg::HRDATA_PAD, next_view}; // RULE19
        end
        else if (addr_phase)
        begin
            hrdata_o <= uhre_pkg::HRDATA_ZERO;
        end
    end

    // ---- software-cleared status flags
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            stalled           <= 1'h0; // RULE1
            nak_timeout_flag  <= 1'h0;
            error_flag        <= 1'h0;
            packet_ready_flag <= 1'h0;
        end
        else
        begin
            stalled           <= next_stalled;
            nak_timeout_flag  <= next_nak;
            error_flag        <= next_error;
            packet_ready_flag <= next_ready;
        end
    end

    // ---- request bit, moved by software and engine alike
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            request_packet <= 1'h0; // RULE1
        end
        else
        begin
            request_packet <= next_request; // RULE4 RULE5
        end
    end

    // ---- data toggle
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            data_toggle <= 1'h0;
        end
        else
        begin
            data_toggle <= next_toggle; // RULE2
        end
    end

    // ---- empty-attempt counter
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            retry_cnt <= uhre_pkg::RETRY_ZERO;
        end
        else
        begin
            retry_cnt <= next_retry; // RULE13
        end
    end

    // ---- engine levels
    // in request stays off while halted so no traffic goes out
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            in_req_o      <= 1'h0;
            halted_o      <= 1'h0;
            data_toggle_o <= 1'h0;
        end
        else
        begin
            in_req_o      <= next_in_req; // RULE4 RULE12
            halted_o      <= next_halted; // RULE12
            data_toggle_o <= next_toggle;
        end
    end

    // ---- engine pulses
    // one pulse per write; the engine drops one packet per pulse
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            flush_o     <= 1'h0;
            irq_event_o <= 1'h0;
        end
        else
        begin
            flush_o     <= flush_hit; // RULE6 RULE7 RULE9
            irq_event_o <= next_irq;  // RULE3 RULE13 RULE16
        end
    end

endmodule

// [src/uhre_pkg.sv]
// constants for the host receive-endpoint low control and status byte
package uhre_pkg;

    // register index as printed; the bus address is four times the index
    localparam logic [11:0] REG_INDEX     = 12'h116;
    localparam logic [31:0] REG_BYTE_ADDR = {18'h0, REG_INDEX, 2'h0};
    localparam int unsigned REG_WIDTH     = 8;
    localparam int unsigned BUS_WIDTH     = 32;
    localparam logic [7:0]  REG_RESET     = 8'h00;

    // bit positions in the low byte
    localparam int unsigned BIT_TOGGLE_RESET = 7;
    localparam int unsigned BIT_STALLED      = 6;
    localparam int unsigned BIT_REQUEST      = 5;
    localparam int unsigned BIT_FLUSH        = 4;
    localparam int unsigned BIT_ERR_NAK      = 3;
    localparam int unsigned BIT_ERROR        = 2;
    localparam int unsigned BIT_FULL         = 1;
    localparam int unsigned BIT_READY        = 0;

    // three attempts without a data packet raise the error flag
    localparam logic [1:0]  RETRY_LIMIT      = 2'h3;
    localparam logic [1:0]  RETRY_STEP       = 2'h1;
    localparam logic [1:0]  RETRY_ZERO       = 2'h0;

    // ahb-lite encodings
    localparam int unsigned HTRANS_ACTIVE_BIT = 1;
    localparam logic        HRESP_OKAY        = 1'h0;
    localparam logic        HREADY_HIGH       = 1'h1;
    localparam logic [31:0] HRDATA_ZERO       = 32'h0000_0000;
    localparam logic [23:0] HRDATA_PAD        = 24'h00_0000;
    localparam int unsigned ADDR_LSB          = 2;

endpackage

// [verification/uhre_chk_asserts.sv]
// concurrent checks on the endpoint status byte ports
`timescale 1ns/1ps
module uhre_chk
(
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hwrite_i,
    input wire logic [31:0] hwdata_i,
    input wire logic        hready_i,
    input wire logic        iso_mode_i,
    input wire logic        stall_rcvd_i,
    input wire logic        data_pkt_i,
    input wire logic        nak_limit_i,
    input wire logic        no_data_i,
    input wire logic        in_req_o,
    input wire logic        halted_o,
    input wire logic        data_toggle_o,
    input wire logic        flush_o,
    input wire logic        irq_event_o
);
    logic wr_ph;
    wire  hit = hsel_i && htrans_i[1] && hwrite_i && haddr_i[31:2] == 30'h116;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // marks the data phase of a write to the byte
    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
            wr_ph <= 1'b0;
        else if (hready_i)
            wr_ph <= hit;
    property p_rdy; data_pkt_i |=> irq_event_o; endproperty
    a_rdy: assert property (p_rdy) else $error("no irq on packet");
    property p_rclr; data_pkt_i |=> !in_req_o; endproperty
    a_rclr: assert property (p_rclr) else $error("request kept");
    property p_stall; stall_rcvd_i |=> irq_event_o; endproperty
    a_stall: assert property (p_stall) else $error("no irq on stall");
    // same-cycle engine events may win over the write
    property p_req;
        wr_ph && hwdata_i[5] && !halted_o
        && !(data_pkt_i || no_data_i || nak_limit_i || stall_rcvd_i) |=> in_req_o;
    endproperty
    a_req: assert property (p_req) else $error("request not issued");
    property p_tog; wr_ph && hwdata_i[7] |=> !data_toggle_o; endproperty
    a_tog: assert property (p_tog) else $error("toggle not reset");
    property p_fl; wr_ph && hwdata_i[4] |=> flush_o ##1 !flush_o; endproperty
    a_fl: assert property (p_fl) else $error("flush pulse wrong");
    property p_nak; nak_limit_i && !iso_mode_i |=> halted_o; endproperty
    a_nak: assert property (p_nak) else $error("no halt");
    property p_hold; halted_o && !(wr_ph && !hwdata_i[3]) |=> halted_o; endproperty
    a_hold: assert property (p_hold) else $error("halt dropped");
    property p_idle; halted_o |-> !in_req_o; endproperty
    a_idle: assert property (p_idle) else $error("request while halted");
endmodule
bind uhre_top uhre_chk u_chk (.clk_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hwdata_i, .hready_i, .iso_mode_i, .stall_rcvd_i, .data_pkt_i, .nak_limit_i,
    .no_data_i, .in_req_o, .halted_o, .data_toggle_o, .flush_o, .irq_event_o);

// [verification/uhre_dev.sv]
// usb function model answering in transactions
`timescale 1ns/1ps
module uhre_dev
(
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic       in_req_i,
    input wire logic [2:0] ans_i,
    output logic           stall_o,
    output logic           data_o,
    output logic           crc_o,
    output logic           nak_o,
    output logic           nodata_o,
    output logic           tog_o
);
    logic [1:0] c;
    wire        hit = in_req_i && c == 2'h2;
    // answers every third cycle while a request is open
    always_ff @(posedge clk_i or negedge nrst_i)
        if (!nrst_i)
        begin
            c <= 2'h0;
            {stall_o, data_o, crc_o, nak_o, nodata_o, tog_o} <= 6'h0;
        end
        else
        begin
            c        <= (in_req_i && !hit) ? c + 2'h1 : 2'h0;
            stall_o  <= hit && ans_i == 3'h3;
            data_o   <= hit && (ans_i == 3'h1 || ans_i == 3'h2);
            // error qualifier is junk outside a packet
            crc_o    <= hit ? ans_i == 3'h2 : ~crc_o;
            nak_o    <= hit && ans_i == 3'h4;
            nodata_o <= hit && ans_i == 3'h5;
            tog_o    <= hit && ans_i == 3'h1;
        end
endmodule

// [verification/uhre_top_tb.sv]
// self-checking bench for the endpoint status byte
`timescale 1ns/1ps
module uhre_top_tb;
    logic        clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0]  htrans_i = 2'h0;
    logic [2:0]  hsize_i = 3'h0;
    logic        hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic        iso_mode_i = 1'b0;
    logic        fifo_full_i = 1'b0;
    logic [2:0]  ans = 3'h0;
    logic [31:0] hrdata_o;
    logic [31:0] r;
    logic        w_irq = 1'b0;
    logic        hreadyout_o, hresp_o, in_req_o, halted_o, data_toggle_o, flush_o;
    logic        irq_event_o, stall, dpkt, crc, nak, nod, tog;
    int          err_total = 0;
    int          n_checks = 0;
    always #25 clk_i = ~clk_i;
    uhre_top DUT (.clk_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
        .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o, .hreadyout_o,
        .hresp_o, .iso_mode_i, .stall_rcvd_i(stall), .data_pkt_i(dpkt), .crc_err_i(crc),
        .nak_limit_i(nak), .no_data_i(nod), .toggle_advance_i(tog), .fifo_full_i,
        .in_req_o, .halted_o, .data_toggle_o, .flush_o, .irq_event_o);
    uhre_dev PRT (.clk_i, .nrst_i, .in_req_i(in_req_o), .ans_i(ans), .stall_o(stall),
        .data_o(dpkt), .crc_o(crc), .nak_o(nak), .nodata_o(nod), .tog_o(tog));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel_i <= 1'b1;
        haddr_i <= a;
        hwrite_i <= w;
        htrans_i <= 2'h2;
        hsize_i <= 3'h2;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_i); while (hreadyout_o !== 1'b1);
        r = hrdata_o;
    endtask
    task rd(input logic [7:0] e);
        bus(1'b0, uhre_pkg::REG_BYTE_ADDR, 32'h0);
        chk(r, {24'h0, e});
    endtask
    task wr(input logic [7:0] d);
        bus(1'b1, uhre_pkg::REG_BYTE_ADDR, {24'h0, d});
    endtask
    // waits for an engine outcome, bounded
    task wt();
        int i;
        i = 0;
        do @(negedge clk_i); while (!(irq_event_o || halted_o) && ++i < 60);
        w_irq = irq_event_o;
        @(posedge clk_i);
    endtask
    task t_data();
        ans <= 3'h1;
        wr(8'h20);
        wt();
        chk({31'h0, w_irq}, 32'h1);
        rd(8'h01);
        chk({31'h0, data_toggle_o}, 32'h1);
        wr(8'h01);
        rd(8'h01);
        wr(8'h91);
        rd(8'h00);
        chk({31'h0, data_toggle_o}, 32'h0);
        wr(8'h20);
        wt();
        wr(8'h11);
        rd(8'h00);
    endtask
    task t_stall();
        ans <= 3'h3;
        wr(8'h20);
        wt();
        chk({31'h0, w_irq}, 32'h1);
        ans <= 3'h0;
        bus(1'b0, uhre_pkg::REG_BYTE_ADDR, 32'h0);
        chk(r & 32'h40, 32'h40);
        wr(8'h00);
        rd(8'h00);
    endtask
    task t_err();
        ans <= 3'h5;
        wr(8'h20);
        wt();
        chk({31'h0, w_irq}, 32'h1);
        rd(8'h04);
        iso_mode_i <= 1'b1;
        rd(8'h00);
        iso_mode_i <= 1'b0;
        wr(8'h00);
        rd(8'h00);
    endtask
    task t_nak();
        ans <= 3'h4;
        wr(8'h20);
        wt();
        rd(8'h28);
        chk({30'h0, halted_o, in_req_o}, 32'h2);
        ans <= 3'h1;
        wr(8'h20);
        wt();
        rd(8'h01);
        wr(8'h00);
    endtask
    task t_iso();
        iso_mode_i <= 1'b1;
        ans <= 3'h2;
        wr(8'h20);
        wt();
        rd(8'h09);
        wr(8'h00);
        rd(8'h00);
        iso_mode_i <= 1'b0;
        fifo_full_i <= 1'b1;
        rd(8'h02);
        fifo_full_i <= 1'b0;
        rd(8'h00);
    endtask
    task tally_and_finish();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(posedge clk_i);
        rd(8'h00);
        chk({30'h0, hresp_o, hreadyout_o}, 32'h1);
        bus(1'b0, uhre_pkg::REG_BYTE_ADDR + 32'h4, 32'h0);
        chk(r, 32'h0);
        t_data();
        t_stall();
        t_err();
        t_nak();
        t_iso();
        tally_and_finish();
    end
    // the run needs well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        tally_and_finish();
    end
endmodule
